// >>> logic/psc_phy_port_select.v
`timescale 1ns/1ps
`default_nettype none

`include "psc_defines.vh"

// Contract
// [RL1] Clock field: 00/11 internal, 01 external, 10 off.
// [RL2] Clock field steers only receive/transmit clocks.
// [RL3] Select bit routes management to internal/external.
// [RL4] Management routing ignores port enable bit.
// [RL5] Select set: internal MDIO and MDC low.
// [RL6] Select clear: external MDIO released, MDC low.
// [RL7] Select bit switches only MDIO and MDC.
// [RL8] Capture external MDIO at hard reset.
// [RL9] Strap bit reads pin level captured.
// [RL10] Strap only visible to software.
// [RL11] Enable bit chooses external port or internal.
// [RL12] Enable bit leaves management and clocks alone.
// [RL13] Soft reset without PHY clocks times out, flags.
// [RL14] Host fixes clocks then retries soft reset.
// [RL15] Writing one starts self-clearing MAC reset.
// [RL16] Clock field resets to internal PHY.
module psc_phy_port_select
#(
  parameter [19:0] SOFT_RST_TMO_CYC = `PSC_SOFT_RST_TMO_CYC
)
(
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire int_rx_clk,
  input wire int_tx_clk,
  input wire ext_rx_clk,
  input wire ext_tx_clk,
  output reg mii_rx_clk_r,
  output reg mii_tx_clk_r,
  output reg ext_mii_en_r,
  output reg int_phy_en_r,
  input wire mac_mdc,
  input wire mac_mdio_out,
  input wire mac_mdio_oe,
  output reg mac_mdio_in_r,
  output reg int_mdc_r,
  output reg int_mdio_out_r,
  output reg int_mdio_oe_r,
  input wire int_mdio_in,
  output reg ext_mdc_r,
  output reg ext_mdio_out_r,
  output reg ext_mdio_oe_r,
  input wire ext_mdio_in,
  output reg mac_soft_reset_r
);

  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_RST = 2'h2;
  localparam [9:0] IDLE_LIMIT = `PSC_CLK_IDLE_CYC;
  localparam [19:0] PULSE_CYC = `PSC_SOFT_RST_PULSE_CYC;

  // Synchronised pins: int rx, int tx, ext rx, ext tx, ext mdio.
  wire [4:0] pin_raw;
  wire [4:0] pin_lvl;
  wire [4:0] pin_edge;

  reg [1:0] clk_src_r;
  reg mgmt_sel_r;
  reg ext_en_r;
  reg strap_r;
  reg [2:0] strap_cnt_r;
  reg rst_tmo_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [19:0] cnt_r;
  reg [19:0] cnt_nxt;
  wire [1:0] clk_run;
  wire both_run;

  reg dp_wr_r;
  reg dp_hit_r;
  wire addr_take;
  wire addr_hit;
  wire soft_rst_start;

  // True when the clock field selects the internal PHY clocks.
  function src_int;
    input [1:0] sel;
    begin
      src_int = (sel == `PSC_CLK_SRC_INT0) || (sel == `PSC_CLK_SRC_INT1);
    end
  endfunction

  // True when the clock field selects the external port clocks.
  function src_ext;
    input [1:0] sel;
    begin
      src_ext = (sel == `PSC_CLK_SRC_EXT);
    end
  endfunction

  assign pin_raw = {ext_mdio_in, ext_tx_clk, ext_rx_clk, int_tx_clk,
                    int_rx_clk};

  // Each of these five pins passes its own synchroniser.
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1)
    begin : g_sync
      psc_pin_sync psc_pin_sync_inst
      (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_in(pin_raw[gi]),
        .level_r(pin_lvl[gi]),
        .edge_r(pin_edge[gi])
      );
    end
  endgenerate

  // A clock counts as running while an edge was seen recently.
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_act
      reg [9:0] idle_cnt_r;
      always @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          idle_cnt_r <= IDLE_LIMIT;
        else if (pin_edge[gi])
          idle_cnt_r <= 10'h000;
        else if (idle_cnt_r != IDLE_LIMIT)
          idle_cnt_r <= idle_cnt_r + 10'h001;
      end
      assign clk_run[gi] = (idle_cnt_r != IDLE_LIMIT);
    end
  endgenerate

  assign both_run = clk_run[0] && clk_run[1];

  // Bus slave answers at once and always with OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_take = hsel && htrans[1] && hready;
  assign addr_hit = (haddr[`PSC_ADDR_W-1:0] == `PSC_CONFIG_ADDR) &&
                    (haddr[31:`PSC_ADDR_W] == 20'h00000);
  assign soft_rst_start = dp_wr_r && dp_hit_r &&
                          hwdata[`PSC_SOFT_RST_BIT] &&
                          (state_r == ST_IDLE); // RL15

  // Address phase is registered; read data is loaded here too.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_wr_r <= 1'b0;
      dp_hit_r <= 1'b0;
      hrdata <= 32'h00000000;
    end
    else
    begin
      dp_wr_r <= addr_take && hwrite && (hsize == `PSC_HSIZE_WORD);
      dp_hit_r <= addr_take && addr_hit;
      if (addr_take && !hwrite)
      begin
        hrdata <= 32'h00000000;
        if (addr_hit)
        begin
          hrdata[`PSC_CLK_SRC_HI:`PSC_CLK_SRC_LO] <= clk_src_r;
          hrdata[`PSC_MGMT_SEL_BIT] <= mgmt_sel_r;
          hrdata[`PSC_STRAP_BIT] <= strap_r;
          hrdata[`PSC_EXT_EN_BIT] <= ext_en_r;
          hrdata[`PSC_RST_TMO_BIT] <= rst_tmo_r;
          hrdata[`PSC_SOFT_RST_BIT] <= (state_r != ST_IDLE); // RL15
        end
      end
    end
  end

  // Writable fields take the data phase word.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      clk_src_r <= `PSC_CLK_SRC_RST; // RL16
      mgmt_sel_r <= `PSC_MGMT_SEL_RST;
      ext_en_r <= `PSC_EXT_EN_RST;
    end
    else if (dp_wr_r && dp_hit_r)
    begin
      clk_src_r <= hwdata[`PSC_CLK_SRC_HI:`PSC_CLK_SRC_LO];
      mgmt_sel_r <= hwdata[`PSC_MGMT_SEL_BIT];
      ext_en_r <= hwdata[`PSC_EXT_EN_BIT];
    end
  end

  // Strap is caught from the settled pin once after hard reset.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      strap_cnt_r <= 3'h0;
      strap_r <= 1'b0;
    end
    else if (strap_cnt_r != `PSC_STRAP_WAIT)
    begin
      strap_cnt_r <= strap_cnt_r + 3'h1;
      if (strap_cnt_r == `PSC_STRAP_WAIT - 3'h1)
        strap_r <= pin_lvl[4]; // RL8 RL9 RL10
    end
  end

  // Soft reset sequencer: wait for PHY clocks, else give up.
  always @*
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      ST_IDLE:
      begin
        cnt_nxt = 20'h00000;
        if (soft_rst_start)
          state_nxt = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (both_run)
        begin
          state_nxt = ST_RST;
          cnt_nxt = 20'h00000;
        end
        else if (cnt_r >= SOFT_RST_TMO_CYC - 20'h00001)
          state_nxt = ST_IDLE; // RL13
        else
          cnt_nxt = cnt_r + 20'h00001;
      end
      ST_RST:
      begin
        if (cnt_r >= PULSE_CYC - 20'h00001)
          state_nxt = ST_IDLE;
        else
          cnt_nxt = cnt_r + 20'h00001;
      end
      default:
      begin
        state_nxt = ST_IDLE;
        cnt_nxt = 20'h00000;
      end
    endcase
  end

  // Sequencer state, timeout flag and the MAC reset output.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 20'h00000;
      rst_tmo_r <= 1'b0;
      mac_soft_reset_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      mac_soft_reset_r <= (state_nxt == ST_RST); // RL15
      if (state_r == ST_WAIT && state_nxt == ST_IDLE)
        rst_tmo_r <= 1'b1; // RL13
      else if (soft_rst_start)
        rst_tmo_r <= 1'b0; // RL14
    end
  end

  // MII clocks follow only the clock field.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mii_rx_clk_r <= 1'b0;
      mii_tx_clk_r <= 1'b0;
    end
    else
    begin
      mii_rx_clk_r <= (src_int(clk_src_r) && pin_lvl[0]) ||
                      (src_ext(clk_src_r) && pin_lvl[2]); // RL1 RL2 RL12
      mii_tx_clk_r <= (src_int(clk_src_r) && pin_lvl[1]) ||
                      (src_ext(clk_src_r) && pin_lvl[3]); // RL1 RL2 RL12
    end
  end

  // Port enable steers the other MII signal paths only.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ext_mii_en_r <= 1'b0;
      int_phy_en_r <= 1'b1;
    end
    else
    begin
      ext_mii_en_r <= ext_en_r; // RL11 RL7
      int_phy_en_r <= !ext_en_r; // RL11
    end
  end

  // Management port routing depends on the select bit alone.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      int_mdc_r <= 1'b0;
      int_mdio_out_r <= 1'b0;
      int_mdio_oe_r <= 1'b0;
      ext_mdc_r <= 1'b0;
      ext_mdio_out_r <= 1'b0;
      ext_mdio_oe_r <= 1'b0;
      mac_mdio_in_r <= 1'b0;
    end
    else if (mgmt_sel_r)
    begin
      int_mdc_r <= 1'b0; // RL5
      int_mdio_out_r <= 1'b0; // RL5
      int_mdio_oe_r <= 1'b1; // RL5
      ext_mdc_r <= mac_mdc; // RL3 RL4
      ext_mdio_out_r <= mac_mdio_out; // RL3
      ext_mdio_oe_r <= mac_mdio_oe; // RL3
      mac_mdio_in_r <= pin_lvl[4]; // RL3
    end
    else
    begin
      int_mdc_r <= mac_mdc; // RL3 RL4
      int_mdio_out_r <= mac_mdio_out; // RL3
      int_mdio_oe_r <= mac_mdio_oe; // RL3
      ext_mdc_r <= 1'b0; // RL6
      ext_mdio_out_r <= 1'b0; // RL6
      ext_mdio_oe_r <= 1'b0; // RL6
      mac_mdio_in_r <= int_mdio_in; // RL3
    end
  end

endmodule
`default_nettype wire

// >>> logic/psc_defines.vh
`ifndef PSC_DEFINES_VH
`define PSC_DEFINES_VH

// Register map, byte addresses on the register bus.
`define PSC_ADDR_W 12
`define PSC_CONFIG_ADDR 12'h074

// Field positions inside the hardware configuration register.
`define PSC_SOFT_RST_BIT 0
`define PSC_RST_TMO_BIT 1
`define PSC_EXT_EN_BIT 2
`define PSC_STRAP_BIT 3
`define PSC_MGMT_SEL_BIT 4
`define PSC_CLK_SRC_LO 5
`define PSC_CLK_SRC_HI 6

// Clock source encodings.
`define PSC_CLK_SRC_INT0 2'h0
`define PSC_CLK_SRC_EXT 2'h1
`define PSC_CLK_SRC_OFF 2'h2
`define PSC_CLK_SRC_INT1 2'h3

// Reset values.
`define PSC_CLK_SRC_RST 2'h0
`define PSC_MGMT_SEL_RST 1'h0
`define PSC_EXT_EN_RST 1'h0

// AHB-Lite encodings.
`define PSC_HSIZE_WORD 3'h2

// Timing: the hclk period and the times in nanoseconds.
`define PSC_HCLK_NS 4
`define PSC_CLK_IDLE_NS 1000
`define PSC_SOFT_RST_TMO_NS 100000
`define PSC_SOFT_RST_PULSE_NS 40

// The same times in hclk cycles, sized for the counters that use them.
`define PSC_CLK_IDLE_CYC 10'h0FA
`define PSC_SOFT_RST_TMO_CYC 20'h061A8
`define PSC_SOFT_RST_PULSE_CYC 20'h0000A

// Strap capture waits until the pin synchroniser holds a settled level.
`define PSC_STRAP_WAIT 3'h5

`endif

// >>> logic/psc_pin_sync.v
`timescale 1ns/1ps
`default_nettype none

module psc_pin_sync
(
  input wire hclk,
  input wire hresetn,
  input wire pin_in,
  output reg level_r,
  output reg edge_r
);

  reg s1_r;
  reg s2_r;
  reg s3_r;
  reg [3:0] fill_r;

  // Three stages; a change counts once the second and third agree.
  // Edges are held off until real samples fill the stages, so that a
  // pin resting high at reset release does not look like a fresh edge.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      fill_r <= 4'h0;
      level_r <= 1'b0;
      edge_r <= 1'b0;
    end
    else
    begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      fill_r <= {fill_r[2:0], 1'b1};
      edge_r <= fill_r[3] && (s2_r == s3_r) && (s3_r != level_r);
      if (s2_r == s3_r)
        level_r <= s3_r;
    end
  end

endmodule
`default_nettype wire

// >>> sim/psc_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "psc_defines.vh"
module psc_props
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic ext_mii_en_r,
  input wire logic int_phy_en_r,
  input wire logic mac_mdio_in_r,
  input wire logic int_mdc_r,
  input wire logic int_mdio_out_r,
  input wire logic int_mdio_oe_r,
  input wire logic int_mdio_in,
  input wire logic ext_mdc_r,
  input wire logic ext_mdio_oe_r,
  input wire logic mac_soft_reset_r
);
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Reads taken on the bus, and those aimed off the mapped word.
  wire rd_take = hsel && htrans[1] && hready && !hwrite;
  wire rd_off = rd_take && haddr != {20'h0, `PSC_CONFIG_ADDR};
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus stalled or errored");
  a_unmapped_zero: assert property (rd_off |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_reserved_zero: assert property (rd_take |=> hrdata[31:7] == 25'h0)
    else $error("reserved read bits set");
  a_pulse_ten: assert property ($rose(mac_soft_reset_r) |=>
    mac_soft_reset_r[*8] ##1 mac_soft_reset_r ##1 !mac_soft_reset_r)
    else $error("soft reset pulse length wrong");
  a_enable_inverse: assert property (ext_mii_en_r != int_phy_en_r)
    else $error("port enables not exclusive");
  a_int_held_low: assert property (ext_mdc_r |->
    !int_mdc_r && !int_mdio_out_r && int_mdio_oe_r)
    else $error("internal management not low");
  a_ext_released: assert property (int_mdc_r |->
    !ext_mdc_r && !ext_mdio_oe_r)
    else $error("external management not idle");
  a_mdio_return: assert property (int_mdc_r |->
    mac_mdio_in_r == $past(int_mdio_in))
    else $error("read back not from internal PHY");
  c_pulse: cover property ($rose(mac_soft_reset_r));
  c_ext: cover property (ext_mdc_r);
  c_off: cover property (rd_off);
endmodule
bind psc_phy_port_select psc_props psc_props_inst (.*);
`default_nettype wire

// >>> sim/psc_phy_model.sv
`timescale 1ns/1ps
`default_nettype none
module psc_phy_model
(
  input wire logic int_run,
  input wire logic ext_run,
  input wire logic strap_pu,
  input wire logic int_mdio_out_r,
  input wire logic int_mdio_oe_r,
  input wire logic ext_mdio_out_r,
  input wire logic ext_mdio_oe_r,
  output logic int_rx_clk,
  output logic int_tx_clk,
  output logic ext_rx_clk,
  output logic ext_tx_clk,
  output logic int_mdio_in,
  output logic ext_mdio_in
);
  logic lk = 1'b0;
  // Link timebase of 48 ns, offset in phase from the bus clock.
  initial
  begin
    #7;
    forever #24 lk = !lk;
  end
  // A stopped PHY holds its clocks still and low.
  assign int_rx_clk = int_run & lk;
  assign int_tx_clk = int_run & !lk;
  assign ext_rx_clk = ext_run & lk;
  assign ext_tx_clk = ext_run & !lk;
  // The internal PHY line reads 0 when undriven; the external pin has a chosen pull.
  assign int_mdio_in = int_mdio_oe_r ? int_mdio_out_r : 1'b0;
  assign ext_mdio_in = ext_mdio_oe_r ? ext_mdio_out_r : strap_pu;
endmodule
`default_nettype wire

// >>> sim/test_phy_port_select_config.sv
`timescale 1ns/1ps
`default_nettype none
module test_phy_port_select_config;
  localparam logic [31:0] A = 32'h00000074;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic mac_mdc = 1, mac_mdio_out = 1, mac_mdio_oe = 0;
  logic int_run = 1, ext_run = 0, strap_pu = 1;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 0, hwdata = 0, d;
  wire hreadyout, hresp, hready, mii_rx_clk_r, mii_tx_clk_r;
  wire ext_mii_en_r, int_phy_en_r, mac_mdio_in_r, int_mdc_r;
  wire int_mdio_out_r, int_mdio_oe_r, ext_mdc_r, ext_mdio_out_r;
  wire ext_mdio_oe_r, mac_soft_reset_r, int_rx_clk, int_tx_clk;
  wire ext_rx_clk, ext_tx_clk, int_mdio_in, ext_mdio_in;
  wire [31:0] hrdata;
  int n_fail = 0, comparisons = 0, n, hi = 0;
  assign hready = hreadyout;
  psc_phy_port_select #(.SOFT_RST_TMO_CYC(20'h00032))
    psc_phy_port_select_inst (.*);
  psc_phy_model psc_phy_model_inst (.*);
  always #2 hclk = !hclk;
  // Counts cycles with the MAC soft reset high.
  always @(posedge hclk) hi <= hi + mac_soft_reset_r;
  task chk(input logic [31:0] g, e);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One single AHB-Lite transfer; read data land in d.
  task bus(input logic w, input logic [31:0] a, wd);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  task rdc(input logic [31:0] e);
    bus(0, A, 0);
    chk(d, e);
  endtask
  task wt(input int k);
    repeat (k) @(posedge hclk);
  endtask
  task hrst(input logic pu);
    strap_pu <= pu;
    hresetn <= 0;
    wt(12);
    hresetn <= 1;
    wt(8);
  endtask
  task final_report;
    if (n_fail == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Defaults after hard reset, with the strap pulled both ways.
  task t_reset;
    hrst(0);
    rdc(32'h0);
    hrst(1);
    rdc(32'h8);
    chk({ext_mii_en_r, int_phy_en_r}, 2'b01);
  endtask
  // An unmapped word reads zero and ignores writes.
  task t_unmap;
    bus(1, 32'h78, 32'h74);
    bus(0, 32'h78, 0);
    chk(d, 0);
    hsize <= 3'h0;
    bus(1, A, 32'h10);
    hsize <= 3'h2;
    rdc(32'h8);
  endtask
  // Every clock code, with one source running at a time.
  task t_clk;
    for (int i = 0; i < 8; i++)
    begin
      int_run <= !i[2];
      ext_run <= i[2];
      bus(1, A, {25'h0, i[1:0], 5'h0});
      wt(12);
      n = 0;
      repeat (48) @(posedge hclk) n += mii_rx_clk_r + mii_tx_clk_r;
      chk(n != 0, i[1:0] == 1 ? i[2] : i[1:0] != 2 && !i[2]);
      chk({int_mdc_r, ext_mdc_r}, 2'b10);
    end
  endtask
  // Management routing against both values of the port enable.
  task t_mgmt;
    for (int i = 0; i < 4; i++)
    begin
      mac_mdio_oe <= i[1];
      bus(1, A, {27'h0, i[0], 1'b0, i[1], 2'h0});
      rdc({27'h0, i[0], 1'b1, i[1], 2'h0});
      wt(8);
      chk({int_mdc_r, int_mdio_out_r, int_mdio_oe_r, ext_mdc_r,
        ext_mdio_out_r, ext_mdio_oe_r, mac_mdio_in_r},
        {!i[0], !i[0], i[0] | i[1], i[0], i[0], i[0] & i[1],
        i[0] | i[1]});
      chk({ext_mii_en_r, int_phy_en_r}, {i[1], !i[1]});
    end
  endtask
  // Soft reset times out with the internal PHY clocks stopped, then succeeds.
  task t_soft_reset_request;
    bus(1, A, 32'h0);
    int_run <= 0;
    wt(300);
    n = hi;
    bus(1, A, 32'h1);
    rdc(32'h9);
    wt(60);
    rdc(32'hA);
    chk(hi - n, 0);
    int_run <= 1;
    wt(20);
    n = hi;
    bus(1, A, 32'h1);
    wt(30);
    chk(hi - n, 10);
    rdc(32'h8);
  endtask
  initial
  begin
    t_reset;
    t_unmap;
    t_clk;
    t_mgmt;
    t_soft_reset_request;
    final_report;
  end
  // Cuts a hang short well past the expected run length.
  initial
  begin
    #40000;
    n_fail++;
    final_report;
  end
endmodule
`default_nettype wire
